// ---- hw/fcs_freq_status.sv ----
`default_nettype none
module fcs_freq_status
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // parameter store
   input wire fcs_cfg_t cfg,
   // drive state
   input wire logic running,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] out_current,
   input wire logic [15:0] digital_freq,
   // analog command inputs, sampled once per tick
   input wire logic [9:0] ain1,
   input wire logic [9:0] ain2,
   // conditioned command
   output logic [15:0] freq_cmd,
   output logic zero_stop,
   output logic [9:0] ain1_filt,
   output logic [9:0] ain2_filt,
   // status outputs
   output logic open_collector_one,
   output logic open_collector_two,
   output logic relay_out,
   output logic [9:0] analog_monitor
);
   // function selector decode, shared by all three outputs
   function automatic logic fn_out(input logic [3:0] code,
                                   input logic fsense,
                                   input logic chi,
                                   input logic clo);
      logic r;
      r = 1'b0;
      case (code)
         FN_FREQ_SENSE: r = fsense;
         FN_CUR_ABOVE: r = chi;
         FN_CUR_BELOW: r = clo;
         default: r = 1'b0;     // other functions live elsewhere
      endcase
      return r;
   endfunction

   // one step of an asymmetric on/off delay, counted in ms ticks
   function automatic logic [14:0] dly_step(input logic raw,
                                             input logic q,
                                             input logic [13:0] cnt,
                                             input logic [13:0] on_ms);
      logic [13:0] lim;
      logic [13:0] nx;
      lim = q ? 14'(OFF_DELAY_MS) : on_ms;
      nx = cnt + 14'h1;
      if (raw == q) begin
         dly_step = {q, 14'h0};       // condition agrees, restart wait
      end else if (nx >= lim) begin
         dly_step = {raw, 14'h0};     // waited long enough, follow
      end else begin
         dly_step = {q, nx};
      end
   endfunction

   // running average, guarded divisor
   function automatic logic [9:0] avg_of(input logic [SUM_W-1:0] s,
                                         input logic [7:0] n);
      avg_of = 10'(s / SUM_W'(n));
   endfunction

   fcs_state_t st_r;   // registered state
   fcs_state_t st_nxt; // next state
   // sample history, one row per analog input
   logic [9:0] hist_mem [2][HIST_DEPTH];

   // combinational helpers
   logic tick;
   logic flush;
   logic [7:0] n_eff;
   logic [PTR_W-1:0] old_ptr;
   logic [SUM_W-1:0] s0_new;
   logic [SUM_W-1:0] s1_new;
   logic analog_src;
   logic [15:0] ceil_eff;
   logic [15:0] floor_eff;
   logic signed [39:0] bg_num;
   logic signed [39:0] bg_freq;
   logic [15:0] raw_freq;
   logic [15:0] clamp_freq;
   logic below_pct;
   logic stop_hit;
   logic [13:0] on_ms;
   logic [14:0] step_hi;
   logic [14:0] step_lo;
   logic [15:0] mon_q;
   logic [15:0] mon_max;
   logic [31:0] ratio;
   logic [31:0] ana_calc;
   logic [31:0] pwm_calc;

   assign tick = (st_r.tick_cnt == 15'(TICK_CYC - 1));

   // filter constant kept inside its legal range; zero never divides
   always_comb begin
      n_eff = cfg.analog_filter_const;
      if (n_eff < FILT_MIN) begin
         n_eff = FILT_MIN;
      end else if (n_eff > FILT_MAX) begin
         n_eff = FILT_MAX;
      end
   end

   // changing N would corrupt the running sums, so history restarts
   assign flush = (n_eff != st_r.filt_n);
   assign old_ptr = st_r.wptr - PTR_W'(n_eff);
   assign s0_new = st_r.sum0 + SUM_W'(ain1) - SUM_W'(hist_mem[0][old_ptr]);
   assign s1_new = st_r.sum1 + SUM_W'(ain2) - SUM_W'(hist_mem[1][old_ptr]);

   // analog command sources are codes 0, 2-6 and 8
   always_comb begin
      case (cfg.freq_command_source)
         4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8: analog_src = 1'b1;
         default: analog_src = 1'b0;
      endcase
   end

   // effective limits
   always_comb begin
      ceil_eff = cfg.max_output_freq;
      if (cfg.freq_ceiling < cfg.max_output_freq) begin
         ceil_eff = cfg.freq_ceiling;
      end
      floor_eff = cfg.freq_floor;
      if (cfg.freq_floor > ceil_eff) begin
         floor_eff = ceil_eff;
      end
   end

   // analog command scaling from the filtered first input
   always_comb begin
      // f = max * (bias*1023 + gain*code) / (1023*1000)
      bg_num = 40'(cfg.command_bias_pct) * 40'sd1023
             + 40'(signed'({1'b0, cfg.command_gain_pct}))
             * 40'(signed'({1'b0, st_r.avg0}));
      bg_freq = bg_num * 40'(signed'({1'b0, cfg.max_output_freq}))
              / 40'(ADC_FS * PERMILLE);
      if (cfg.bias_gain_enable) begin
         if (bg_freq < 40'sd0) begin
            raw_freq = 16'h0;
         end else if (bg_freq > 40'sd65535) begin
            raw_freq = 16'hFFFF;
         end else begin
            raw_freq = 16'(bg_freq);
         end
      end else begin
         raw_freq = 16'(32'(st_r.avg0) * 32'(cfg.max_output_freq)
                   / 32'(ADC_FS));
      end
      if (!analog_src) begin
         raw_freq = digital_freq;
      end
      below_pct = analog_src && (32'(st_r.avg0) * 32'(PCT_DIV) < 32'(ADC_FS));
      if (below_pct) begin
         raw_freq = 16'h0;
      end
      stop_hit = analog_src && (cfg.zero_stop_threshold != 16'h0)
               && (raw_freq <= cfg.zero_stop_threshold);
      clamp_freq = raw_freq;
      if (clamp_freq > ceil_eff) begin
         clamp_freq = ceil_eff;
      end
      if (clamp_freq < floor_eff) begin
         clamp_freq = floor_eff;
      end
   end

   // current sensing on-delay converted from 0.1 s units to ms
   assign on_ms = 14'(32'(cfg.current_sense_on_delay) * ON_DELAY_UNIT_MS);
   assign step_hi = dly_step(out_current > cfg.current_sense_level,
                             st_r.cur_hi, st_r.dly_hi, on_ms);
   assign step_lo = dly_step(out_current < cfg.current_sense_level,
                             st_r.cur_lo, st_r.dly_lo, on_ms);

   // monitor level and duty for the coming period
   always_comb begin
      mon_q = cfg.monitor_source_sel ? out_current : out_freq;
      mon_max = cfg.monitor_source_sel ? 16'(CUR_FULL_SCALE)
                                       : cfg.max_output_freq;
      if (mon_max == 16'h0) begin
         mon_max = 16'h1;
      end
      ratio = 32'(mon_q) * 32'(RATIO_ONE) / 32'(mon_max);
      if (ratio > 32'(RATIO_ONE)) begin
         ratio = 32'(RATIO_ONE);
      end
      if (!running) begin
         ratio = 32'h0;
      end
      ana_calc = 32'(ADC_FS) * (32'(ANA_OFS) + 32'(cfg.monitor_full_scale_comp))
               / 32'(ANA_DEN) * ratio / 32'(RATIO_ONE);
      pwm_calc = 32'(TICK_CYC) * (32'(PWM_OFS)
               + 32'(cfg.monitor_full_scale_comp))
               / 32'(PWM_DEN) * ratio / 32'(RATIO_ONE);
   end

   // next state
   always_comb begin
      st_nxt = st_r;
      // ms divider doubles as the pwm period counter
      st_nxt.tick_cnt = tick ? 15'h0 : st_r.tick_cnt + 15'h1;
      // duty and level change only at a period edge, so no runt pulses
      if (tick) begin
         st_nxt.pwm_hi = 15'(pwm_calc);
         st_nxt.ana_mon = 10'(ana_calc);
      end
      st_nxt.pwm_q = (st_nxt.tick_cnt < st_nxt.pwm_hi);
      // current sensing qualifiers advance once per ms
      if (tick) begin
         {st_nxt.cur_hi, st_nxt.dly_hi} = step_hi;
         {st_nxt.cur_lo, st_nxt.dly_lo} = step_lo;
      end
      // filter bookkeeping
      st_nxt.filt_n = n_eff;
      if (flush) begin
         st_nxt.sum0 = '0;
         st_nxt.sum1 = '0;
         st_nxt.wptr = '0;
      end else if (tick) begin
         st_nxt.sum0 = s0_new;
         st_nxt.sum1 = s1_new;
         st_nxt.avg0 = avg_of(s0_new, n_eff);
         st_nxt.avg1 = avg_of(s1_new, n_eff);
         st_nxt.wptr = st_r.wptr + PTR_W'(1);
      end
      // command: zero-stop forces zero output frequency
      st_nxt.zero_stop = stop_hit;
      st_nxt.freq_cmd = stop_hit ? 16'h0 : clamp_freq;
      // status outputs; code 13 only meaningful on output one
      st_nxt.oc1 = (cfg.oc1_function_sel == FN_PWM) ? st_nxt.pwm_q
                 : fn_out(cfg.oc1_function_sel,
                          out_freq > cfg.tr_sense_freq,
                          st_r.cur_hi, st_r.cur_lo);
      st_nxt.oc2 = fn_out(cfg.oc2_function_sel,
                          out_freq > cfg.tr_sense_freq,
                          st_r.cur_hi, st_r.cur_lo);
      st_nxt.relay = fn_out(cfg.relay_function_sel,
                            out_freq > cfg.relay_sense_freq,
                            st_r.cur_hi, st_r.cur_lo);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.filt_n <= FILT_MIN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // history memory; cleared on reset and on a filter constant change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
               hist_mem[c][i] <= '0;
            end
         end
      end else if (flush) begin
         for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
               hist_mem[c][i] <= '0;
            end
         end
      end else if (tick) begin
         hist_mem[0][st_r.wptr] <= ain1;
         hist_mem[1][st_r.wptr] <= ain2;
      end
   end

   // outputs straight from state
   assign freq_cmd = st_r.freq_cmd;
   assign zero_stop = st_r.zero_stop;
   assign ain1_filt = st_r.avg0;
   assign ain2_filt = st_r.avg1;
   assign open_collector_one = st_r.oc1;
   assign open_collector_two = st_r.oc2;
   assign relay_out = st_r.relay;
   assign analog_monitor = st_r.ana_mon;
endmodule // fcs_freq_status
`default_nettype wire

// ---- hw/fcs_pkg.sv ----
// How it works
// - open-collector frequency sensing threshold, 0.5-400 Hz
// - separate relay threshold; zero code means 0.0
// - one shared current sensing level, 0.1-100 A
// - programmable current sensing on-delay, 0.1-10 s
// - fixed current sensing off-delay of 100 ms
// - monitor source bit: frequency or current
// - pwm status signal has 1 ms period
// - pwm reaches output one only on code 13
// - monitor outputs zero while inverter stopped
// - full-scale compensation 25-100 percent scales monitors
// - clamp output frequency between floor and ceiling
// - ceiling wins when below maximum frequency
// - ceiling wins when floor exceeds ceiling
// - zero-stop zero code disables, else threshold
// - analog command at threshold stops output
// - no zero-stop for digital or communication commands
// - below 1 percent is 0 Hz, run at floor
// - bias and gain applied only when enabled
// - bias and gain are ratios of maximum frequency
// - saturate scaled command to floor and ceiling
// - negative scaled command never reverses direction
// - one shared filter constant 5-200 for inputs
// - function code 4 on above sensing threshold
// - code 5 current above, code 6 below
`default_nettype none
package fcs_pkg;
   // clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_TIME_US = 1000;      // monitor period, 1 ms
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int OFF_DELAY_MS = 100;       // fixed current off-delay
   localparam int ON_DELAY_UNIT_MS = 100;   // on-delay setting step 0.1 s
   // analog input scale
   localparam int ADC_W = 10;
   localparam int ADC_FS = 1023;
   localparam int PCT_DIV = 100;            // 1 percent of full scale
   localparam int PERMILLE = 1000;          // bias/gain held in 0.1 %
   // filter history
   localparam int HIST_DEPTH = 256;
   localparam int PTR_W = 8;
   localparam int SUM_W = 18;
   localparam logic [7:0] FILT_MIN = 8'd5;
   localparam logic [7:0] FILT_MAX = 8'd200;
   // monitor scaling
   localparam int RATIO_ONE = 1024;         // ratio fixed point, 1.0
   localparam int CUR_FULL_SCALE = 1000;    // current at full scale, 0.1 A
   localparam int ANA_OFS = 20;             // analog fs = 1023*(20+c)/120
   localparam int ANA_DEN = 120;
   localparam int PWM_OFS = 200;            // pwm fs = 25000*(200+c)/400
   localparam int PWM_DEN = 400;
   // output function selector codes
   localparam logic [3:0] FN_FREQ_SENSE = 4'h4;
   localparam logic [3:0] FN_CUR_ABOVE = 4'h5;
   localparam logic [3:0] FN_CUR_BELOW = 4'h6;
   localparam logic [3:0] FN_PWM = 4'hD;

   // parameter store image, frequencies in 0.1 Hz, current in 0.1 A
   typedef struct packed {
      logic [15:0] tr_sense_freq;
      logic [15:0] relay_sense_freq;
      logic [15:0] current_sense_level;
      logic [6:0] current_sense_on_delay;   // 0.1 s units
      logic monitor_source_sel;
      logic [6:0] monitor_full_scale_comp;  // percent
      logic [15:0] freq_floor;
      logic [15:0] freq_ceiling;
      logic [15:0] zero_stop_threshold;     // zero code disables
      logic [15:0] max_output_freq;
      logic bias_gain_enable;
      logic signed [12:0] command_bias_pct; // 0.1 %
      logic [12:0] command_gain_pct;        // 0.1 %
      logic [7:0] analog_filter_const;
      logic [3:0] oc1_function_sel;
      logic [3:0] oc2_function_sel;
      logic [3:0] relay_function_sel;
      logic [3:0] freq_command_source;
   } fcs_cfg_t;

   // register state of the block, apart from the history memory
   typedef struct packed {
      logic [14:0] tick_cnt;
      logic [14:0] pwm_hi;
      logic pwm_q;
      logic [9:0] ana_mon;
      logic cur_hi;
      logic cur_lo;
      logic [13:0] dly_hi;
      logic [13:0] dly_lo;
      logic [15:0] freq_cmd;
      logic zero_stop;
      logic oc1;
      logic oc2;
      logic relay;
      logic [PTR_W-1:0] wptr;
      logic [SUM_W-1:0] sum0;
      logic [SUM_W-1:0] sum1;
      logic [9:0] avg0;
      logic [9:0] avg1;
      logic [7:0] filt_n;
   } fcs_state_t;
endpackage : fcs_pkg
`default_nettype wire

// ---- testbench/fcs_ctrl_model.sv ----
`default_nettype none
// controller that times the status line of output one
module fcs_ctrl_model
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // observed status line
   input wire logic open_collector_one,
   // measurements, in clock cycles
   output logic [31:0] period,
   output logic [31:0] high_len,
   output logic [31:0] hi_total
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_r; // last sample, for edge finding
   logic [31:0] cnt_r; // cycles since last rising edge
   logic [31:0] hcnt_r; // high cycles since last rising edge
   // rising edge closes one period of the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         cnt_r <= 32'h0;
         hcnt_r <= 32'h0;
         period <= 32'h0;
         high_len <= 32'h0;
         hi_total <= 32'h0;
      end else begin
         prev_r <= open_collector_one;
         hi_total <= hi_total + 32'(open_collector_one);
         if (open_collector_one && !prev_r) begin
            period <= cnt_r;
            high_len <= hcnt_r;
            cnt_r <= 32'h1;
            hcnt_r <= 32'h1;
         end else begin
            cnt_r <= cnt_r + 32'h1;
            hcnt_r <= hcnt_r + 32'(open_collector_one);
         end
      end
   end
endmodule // fcs_ctrl_model
`default_nettype wire

// ---- testbench/fcs_status_monitor.sv ----
`default_nettype none
module fcs_status_monitor
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched inputs
   input wire fcs_cfg_t cfg,
   input wire logic running,
   input wire logic [15:0] out_current,
   input wire logic [15:0] out_freq,
   // watched outputs
   input wire logic [15:0] freq_cmd,
   input wire logic zero_stop,
   input wire logic open_collector_one,
   input wire logic open_collector_two,
   input wire logic relay_out,
   input wire logic [9:0] analog_monitor
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] above_r; // cycles with current above level
   logic [31:0] below_r; // cycles with current at or below level
   logic [31:0] idle_r; // cycles with inverter stopped
   logic dig; // command not from an analog source
   assign dig = !(cfg.freq_command_source inside
      {4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8});
   // counters stand in for delays far beyond a repetition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         above_r <= 32'h0;
         below_r <= 32'h0;
         idle_r <= 32'h0;
      end else begin
         above_r <= (out_current > cfg.current_sense_level) ?
            above_r + 32'h1 : 32'h0;
         below_r <= (out_current > cfg.current_sense_level) ?
            32'h0 : below_r + 32'h1;
         idle_r <= running ? 32'h0 : idle_r + 32'h1;
      end
   end
   sequence s_cur_rise;
      cfg.oc1_function_sel == FN_CUR_ABOVE ##1 $rose(open_collector_one);
   endsequence
   sequence s_cur_fall;
      cfg.oc1_function_sel == FN_CUR_ABOVE ##1 $fell(open_collector_one);
   endsequence
   AST_FSENSE_ON: assert property (cfg.oc1_function_sel == FN_FREQ_SENSE
      && out_freq > cfg.tr_sense_freq |=> open_collector_one)
      else $error("output one missed frequency sensing");
   AST_FSENSE_OFF: assert property (cfg.oc1_function_sel == FN_FREQ_SENSE
      && out_freq <= cfg.tr_sense_freq |=> !open_collector_one)
      else $error("output one on at or below threshold");
   AST_RELAY_SENSE: assert property (cfg.relay_function_sel == FN_FREQ_SENSE
      |=> relay_out == $past(out_freq > cfg.relay_sense_freq))
      else $error("relay frequency sensing wrong");
   AST_OC2_NO_PWM: assert property (cfg.oc2_function_sel == FN_PWM
      |=> !open_collector_two) else $error("pwm reached output two");
   AST_CEILING: assert property (1'b1 |=> freq_cmd <= $past(cfg.freq_ceiling)
      && freq_cmd <= $past(cfg.max_output_freq))
      else $error("command above ceiling or maximum");
   AST_FLOOR: assert property (dig && cfg.freq_floor <= cfg.freq_ceiling
      && cfg.freq_floor <= cfg.max_output_freq
      |=> freq_cmd >= $past(cfg.freq_floor)) else $error("command below floor");
   AST_DIG_NO_ZSTOP: assert property (dig |=> !zero_stop)
      else $error("zero-stop on digital command");
   AST_ZSTOP_OFF: assert property (cfg.zero_stop_threshold == 16'h0000
      |=> !zero_stop) else $error("zero-stop while disabled");
   AST_ZSTOP_ZERO: assert property (zero_stop |-> freq_cmd == 16'h0000)
      else $error("command nonzero in zero-stop");
   AST_ON_DELAY: assert property (s_cur_rise |-> above_r + 32'd50000
      >= 32'(cfg.current_sense_on_delay) * 32'd2500000)
      else $error("current sensing on too early");
   AST_OFF_DELAY: assert property (s_cur_fall |-> below_r >= 32'd2450000)
      else $error("current sensing off too early");
   AST_STOP_ZERO: assert property (idle_r > 32'd26000
      |-> analog_monitor == 10'h000) else $error("monitor not zero when stopped");
endmodule // fcs_status_monitor
bind fcs_freq_status fcs_status_monitor u_mon (.clk(clk), .rst_n(rst_n),
   .cfg(cfg), .running(running), .out_current(out_current),
   .out_freq(out_freq), .freq_cmd(freq_cmd), .zero_stop(zero_stop),
   .open_collector_one(open_collector_one),
   .open_collector_two(open_collector_two), .relay_out(relay_out),
   .analog_monitor(analog_monitor));
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top
   import fcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, running, zero_stop, oc1, oc2, rly;
   fcs_cfg_t cfg;
   logic [15:0] out_freq, out_current, digital_freq, freq_cmd;
   logic [9:0] ain1, ain2, ain1_filt, ain2_filt, analog_monitor;
   logic [31:0] period, high_len, hi_total, h0;
   int n_mismatch, samples_checked;
   fcs_freq_status u_fcs_freq_status (.clk(clk), .rst_n(rst_n), .cfg(cfg),
      .running(running), .out_freq(out_freq), .out_current(out_current),
      .digital_freq(digital_freq), .ain1(ain1), .ain2(ain2),
      .freq_cmd(freq_cmd), .zero_stop(zero_stop), .ain1_filt(ain1_filt),
      .ain2_filt(ain2_filt), .open_collector_one(oc1),
      .open_collector_two(oc2), .relay_out(rly),
      .analog_monitor(analog_monitor));
   fcs_ctrl_model u_fcs_ctrl_model (.clk(clk), .rst_n(rst_n),
      .open_collector_one(oc1), .period(period), .high_len(high_len),
      .hi_total(hi_total));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %0d exp %0d", $time, got, exp);
      end
   endtask
   // monitor scaling truncates, so allow a couple of counts
   function automatic logic near(input logic [31:0] a, input logic [31:0] b);
      return (a + 32'h2 >= b) && (a <= b + 32'h2);
   endfunction
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one threshold for both open collectors, another for the relay
   task automatic t_sense();
      cfg.tr_sense_freq = 16'h01F4;
      cfg.oc1_function_sel = FN_FREQ_SENSE;
      cfg.oc2_function_sel = FN_PWM;
      cfg.relay_function_sel = FN_FREQ_SENSE;
      out_freq = 16'h01F5;
      wait_cyc(3);
      chk(oc1, 1'b1);
      chk(rly, 1'b1);
      chk(oc2, 1'b0);
      cfg.oc2_function_sel = FN_FREQ_SENSE;
      cfg.relay_sense_freq = 16'h03E8;
      out_freq = 16'h01F4;
      wait_cyc(3);
      chk(oc1, 1'b0);
      chk(oc2, 1'b0);
      chk(rly, 1'b0);
      $display("sense test done");
   endtask
   task automatic row(input logic [15:0] f, c, m, d, e);
      cfg.freq_floor = f;
      cfg.freq_ceiling = c;
      cfg.max_output_freq = m;
      digital_freq = d;
      wait_cyc(3);
      chk(freq_cmd, e);
   endtask
   // digital command against floor, ceiling and maximum
   task automatic t_clamp();
      cfg.freq_command_source = 4'h1;
      row(16'h0064, 16'h0BB8, 16'h0FA0, 16'h1388, 16'h0BB8);
      row(16'h0064, 16'h0FA0, 16'h0DAC, 16'h1388, 16'h0DAC);
      row(16'h0064, 16'h0BB8, 16'h0FA0, 16'h000A, 16'h0064);
      row(16'h01F4, 16'h012C, 16'h0FA0, 16'h000A, 16'h012C);
      $display("clamp test done");
   endtask
   // analog command at zero: stop for analog codes only
   task automatic t_zstop();
      logic an;
      row(16'h0064, 16'h0BB8, 16'h0FA0, 16'h07D0, 16'h07D0);
      cfg.zero_stop_threshold = 16'h0032;
      for (int i = 0; i < 9; i++) begin
         an = i inside {0, 2, 3, 4, 5, 6, 8};
         cfg.freq_command_source = 4'(i);
         wait_cyc(3);
         chk(zero_stop, an);
         chk(freq_cmd, an ? 16'h0000 : 16'h07D0);
      end
      cfg.freq_command_source = 4'h0;
      cfg.zero_stop_threshold = 16'h0000;
      wait_cyc(3);
      chk(zero_stop, 1'b0);
      chk(freq_cmd, 16'h0064);
      $display("zero-stop test done");
   endtask
   // current sensing must not follow the condition at once
   task automatic t_cur();
      cfg.current_sense_level = 16'h0064;
      cfg.current_sense_on_delay = 7'h01;
      out_current = 16'h00C8;
      wait_cyc(2);
      cfg.oc1_function_sel = FN_CUR_ABOVE;
      cfg.oc2_function_sel = FN_CUR_BELOW;
      wait_cyc(200);
      chk(oc1, 1'b0);
      chk(oc2, 1'b0);
      $display("current test done");
   endtask
   // stopped gives zero; full frequency gives full-scale duty and level
   task automatic t_mon();
      cfg.oc1_function_sel = FN_PWM;
      cfg.monitor_source_sel = 1'b1;
      cfg.monitor_full_scale_comp = 7'h64;
      out_current = 16'h01F4;
      // both analog inputs steady, so the averages climb one sample a tick
      ain1 = 10'h1F4;
      ain2 = 10'h1F4;
      h0 = hi_total;
      wait_cyc(26000);
      chk(analog_monitor, 10'h000);
      chk(ain2_filt, 10'h064);
      chk(hi_total - h0, 32'h0);
      running = 1'b1;
      cfg.monitor_source_sel = 1'b0;
      out_freq = 16'h0FA0;
      wait_cyc(51000);
      chk(period, 32'h61A8);
      chk(near(high_len, 32'h493E), 1'b1);
      chk(near(32'(analog_monitor), 32'h3FF), 1'b1);
      // three samples of 500 over a window of five give 300
      chk(ain1_filt, 10'h12C);
      chk(ain2_filt, 10'h12C);
      // plain scaling: 300 of 1023 at 400 Hz maximum
      chk(freq_cmd, 16'h0495);
      cfg.bias_gain_enable = 1'b1;
      cfg.command_gain_pct = 13'h07D0;
      wait_cyc(3);
      chk(freq_cmd, 16'h092A);
      // bias of -99 percent drives the command negative: floor, no reverse
      cfg.command_bias_pct = 13'h1C22;
      cfg.command_gain_pct = 13'h03E8;
      wait_cyc(3);
      chk(freq_cmd, 16'h0064);
      $display("monitor test done");
   endtask
   initial begin
      rst_n = 1'b0;
      running = 1'b0;
      cfg = '0;
      cfg.analog_filter_const = 8'h05;
      out_freq = 16'h0000;
      out_current = 16'h0000;
      digital_freq = 16'h0000;
      ain1 = 10'h000;
      ain2 = 10'h000;
      n_mismatch = 0;
      samples_checked = 0;
      wait_cyc(16);
      rst_n = 1'b1;
      wait_cyc(1);
      t_sense();
      t_clamp();
      t_zstop();
      t_cur();
      t_mon();
      wrap_up();
   end
   // cut a hang well after the planned 77300 cycles or so
   initial begin
      repeat (120000) @(posedge clk);
      n_mismatch++;
      $display("BAD t=%0t watchdog expired", $time);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
